// >>> hw/ivp_pkg.sv
// Package of constants and carrier types for the interrupt vector placement block
package ivp_pkg;

  localparam int unsigned ADDR_W        = 13;
  localparam int unsigned SRC_W         = 5;
  localparam int unsigned CTL_W         = 8;

  // Program word addresses
  localparam logic [12:0] RESET_ADDR_APP = 13'h0000;
  localparam logic [12:0] BOOT_START_8K  = 13'h0C00;
  localparam logic [12:0] SLOT_16K       = 13'h0002;
  localparam logic [12:0] SLOT_8K        = 13'h0001;

  // Source index 0 is vector 2, index 24 is vector 26
  localparam logic [4:0]  SRC_LAST       = 5'h18;

  // Control register layout
  localparam int unsigned CTL_CE_BIT     = 0;
  localparam int unsigned CTL_SEL_BIT    = 1;
  localparam logic [7:0]  CTL_RESET      = 8'h00;

  // Change window length in cycles and its counter reset
  localparam logic [2:0]  CE_WINDOW      = 3'h4;
  localparam logic [2:0]  CE_IDLE        = 3'h0;

  // Boot-reset fuse encoding: one is unprogrammed
  localparam logic        FUSE_UNPROG    = 1'b1;

  // Cycles the strap synchronisers get before capture
  localparam logic [1:0]  STRAP_SETTLE   = 2'h2;

  typedef struct packed {
    logic             valid;
    logic [SRC_W-1:0] src;
  } ivp_ack_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } ivp_fetch_t;

  typedef enum logic [1:0] {
    IVP_SETTLE,
    IVP_CAPTURE,
    IVP_RUN
  } ivp_state_t;

endpackage

// >>> hw/ivp_ctl_reg.sv
// Core control register holding vector select and its change enable
`timescale 1ns/1ps

module ivp_ctl_reg (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Register write and read
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  // Control output
  output logic            vector_select_bit
);

  logic       sel_q;
  logic       ce_q;
  logic [2:0] window_q;
  logic       window_open;

  assign window_open = (window_q != ivp_pkg::CE_IDLE);

  // Writing one to change-enable opens a four-cycle window
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      window_q <= ivp_pkg::CE_IDLE;
    else if (wr_en && wr_data[ivp_pkg::CTL_CE_BIT])
      window_q <= ivp_pkg::CE_WINDOW;
    else if (wr_en && window_open)
      window_q <= ivp_pkg::CE_IDLE;
    else if (window_open)
      window_q <= window_q - 3'h1;
  end

  // Select only moves on a write inside the window with change-enable zero
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      sel_q <= ivp_pkg::CTL_RESET[ivp_pkg::CTL_SEL_BIT];
    else if (wr_en && window_open && !wr_data[ivp_pkg::CTL_CE_BIT])
      sel_q <= wr_data[ivp_pkg::CTL_SEL_BIT];
  end

  // Change-enable reads back set while the window is open
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ce_q <= ivp_pkg::CTL_RESET[ivp_pkg::CTL_CE_BIT];
    else
      ce_q <= (wr_en && wr_data[ivp_pkg::CTL_CE_BIT]) || (window_open && !wr_en && window_q != 3'h1);
  end

  // Unused bits of this register read as zero
  always_comb
  begin
    rd_data                          = ivp_pkg::CTL_RESET;
    rd_data[ivp_pkg::CTL_SEL_BIT]    = sel_q;
    rd_data[ivp_pkg::CTL_CE_BIT]     = ce_q;
  end

  assign vector_select_bit = sel_q;

endmodule // ivp_ctl_reg

// >>> hw/ivp_top.sv
// Reset and interrupt vector address generator
`timescale 1ns/1ps

module ivp_top (
  // Clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           resetn,
  // Straps from fuses and part option
  input  wire logic                           boot_reset_fuse,
  input  wire logic                           part_is_8k,
  input  wire logic [ivp_pkg::ADDR_W-1:0]     boot_start_addr,
  // Core control register access
  input  wire logic                           ctl_wr_en,
  input  wire logic [ivp_pkg::CTL_W-1:0]      ctl_wr_data,
  output logic      [ivp_pkg::CTL_W-1:0]      ctl_rd_data,
  // Interrupt acknowledge from the core
  input  wire ivp_pkg::ivp_ack_t              ack_in,
  // Fetch addresses to the core
  output ivp_pkg::ivp_fetch_t                 reset_fetch,
  output ivp_pkg::ivp_fetch_t                 vector_fetch,
  // Status
  output logic                                vector_select_bit,
  output logic                                straps_ready
);

  logic                      fuse_s1_q;
  logic                      fuse_s2_q;
  logic                      part_s1_q;
  logic                      part_s2_q;
  logic [ivp_pkg::ADDR_W-1:0] boot_s1_q;
  logic [ivp_pkg::ADDR_W-1:0] boot_s2_q;

  logic                      fuse_q;
  logic                      part8k_q;
  logic [ivp_pkg::ADDR_W-1:0] boot_q;
  logic [1:0]                settle_q;
  ivp_pkg::ivp_state_t       state_q;
  ivp_pkg::ivp_fetch_t       reset_fetch_q;
  ivp_pkg::ivp_fetch_t       vector_fetch_q;

  logic [ivp_pkg::ADDR_W-1:0] boot_eff;
  logic [ivp_pkg::ADDR_W-1:0] slot;
  logic [ivp_pkg::ADDR_W-1:0] table_base;
  logic [ivp_pkg::ADDR_W-1:0] vec_num;
  logic [ivp_pkg::ADDR_W-1:0] vec_addr;
  logic [ivp_pkg::ADDR_W-1:0] reset_addr;

  ivp_ctl_reg u_ctl (
    .sys_clk           (sys_clk),
    .resetn            (resetn),
    .wr_en             (ctl_wr_en),
    .wr_data           (ctl_wr_data),
    .rd_data           (ctl_rd_data),
    .vector_select_bit (vector_select_bit)
  );

  // Straps come from outside the clock domain
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fuse_s1_q <= ivp_pkg::FUSE_UNPROG;
      fuse_s2_q <= ivp_pkg::FUSE_UNPROG;
      part_s1_q <= 1'b0;
      part_s2_q <= 1'b0;
      boot_s1_q <= ivp_pkg::RESET_ADDR_APP;
      boot_s2_q <= ivp_pkg::RESET_ADDR_APP;
    end
    else
    begin
      fuse_s1_q <= boot_reset_fuse;
      fuse_s2_q <= fuse_s1_q;
      part_s1_q <= part_is_8k;
      part_s2_q <= part_s1_q;
      boot_s1_q <= boot_start_addr;
      boot_s2_q <= boot_s1_q;
    end
  end

  // Sequencer: let synchronisers fill, capture straps once, then run
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q  <= ivp_pkg::IVP_SETTLE;
      settle_q <= 2'h0;
    end
    else
    begin
      unique case (state_q)
        ivp_pkg::IVP_SETTLE:
        begin
          settle_q <= settle_q + 2'h1;
          if (settle_q == ivp_pkg::STRAP_SETTLE)
            state_q <= ivp_pkg::IVP_CAPTURE;
        end
        ivp_pkg::IVP_CAPTURE:
          state_q <= ivp_pkg::IVP_RUN;
        ivp_pkg::IVP_RUN:
          state_q <= ivp_pkg::IVP_RUN;
        // Unused fourth code falls back to settling
        default:
          state_q <= ivp_pkg::IVP_SETTLE;
      endcase
    end
  end

  // Fuses are read once per reset; later pin changes have no effect
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fuse_q   <= ivp_pkg::FUSE_UNPROG;
      part8k_q <= 1'b0;
      boot_q   <= ivp_pkg::RESET_ADDR_APP;
    end
    else if (state_q == ivp_pkg::IVP_SETTLE && settle_q == ivp_pkg::STRAP_SETTLE)
    begin
      fuse_q   <= fuse_s2_q;
      part8k_q <= part_s2_q;
      boot_q   <= boot_s2_q;
    end
  end

  // 8K part covers only the 2K-byte boot section case
  assign boot_eff   = part8k_q ? ivp_pkg::BOOT_START_8K : boot_q;
  assign slot       = part8k_q ? ivp_pkg::SLOT_8K : ivp_pkg::SLOT_16K;

  // Fuse value one means unprogrammed
  assign reset_addr = (fuse_q == ivp_pkg::FUSE_UNPROG) ? ivp_pkg::RESET_ADDR_APP : boot_eff;

  assign table_base = vector_select_bit ? boot_eff : ivp_pkg::RESET_ADDR_APP;

  // Source index 0 is vector number 2, whose offset is one slot
  assign vec_num    = ivp_pkg::ADDR_W'(ack_in.src) + 13'h0001;

  // Product of small values; cast keeps address width
  assign vec_addr   = ivp_pkg::ADDR_W'(table_base + ivp_pkg::ADDR_W'(vec_num * slot));

  // One reset fetch per reset, after straps are captured
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      reset_fetch_q <= '0;
    else
    begin
      reset_fetch_q.valid <= (state_q == ivp_pkg::IVP_CAPTURE);
      if (state_q == ivp_pkg::IVP_CAPTURE)
        reset_fetch_q.addr <= reset_addr;
    end
  end

  // Vector goes out only on an acknowledge of a legal source
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      vector_fetch_q <= '0;
    else
    begin
      vector_fetch_q.valid <= ack_in.valid && (ack_in.src <= ivp_pkg::SRC_LAST) && (state_q == ivp_pkg::IVP_RUN);
      if (ack_in.valid && (ack_in.src <= ivp_pkg::SRC_LAST))
        vector_fetch_q.addr <= vec_addr;
    end
  end

  assign reset_fetch  = reset_fetch_q;
  assign vector_fetch = vector_fetch_q;
  assign straps_ready = (state_q == ivp_pkg::IVP_RUN);

endmodule // ivp_top

// >>> tb/ivp_props.sv
// Checker for the vector placement block ports
`timescale 1ns/1ps
module ivp_props (
  input wire logic                sys_clk, resetn, boot_reset_fuse, part_is_8k,
  input wire logic                ctl_wr_en, vector_select_bit, straps_ready,
  input wire logic [12:0]         boot_start_addr,
  input wire logic [7:0]          ctl_wr_data, ctl_rd_data,
  input wire ivp_pkg::ivp_ack_t   ack_in,
  input wire ivp_pkg::ivp_fetch_t reset_fetch, vector_fetch
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic [12:0] boot, slot, vexp;
  logic        ok;
  // Straps assumed held steady after release
  assign boot = part_is_8k ? ivp_pkg::BOOT_START_8K : boot_start_addr;
  assign slot = part_is_8k ? ivp_pkg::SLOT_8K : ivp_pkg::SLOT_16K;
  assign ok = ack_in.valid && ack_in.src <= ivp_pkg::SRC_LAST && straps_ready;
  assign vexp = (vector_select_bit ? boot : 13'h0000) + (13'(ack_in.src) + 13'h0001) * slot;
  a_ack_answered: assert property (ok |=> vector_fetch.valid) else $error("ack lost");
  a_fetch_cause: assert property (vector_fetch.valid |-> $past(ok)) else $error("stray fetch");
  a_vector_addr: assert property (ok |=> vector_fetch.addr == $past(vexp)) else $error("bad vector");
  a_reset_addr: assert property (reset_fetch.valid |-> reset_fetch.addr == (boot_reset_fuse ? 13'h0000 : boot))
    else $error("bad reset addr");
  a_reset_start: assert property ($rose(straps_ready) |-> reset_fetch.valid) else $error("no reset fetch");
  a_reset_once: assert property (reset_fetch.valid |=> !reset_fetch.valid) else $error("long reset fetch");
  a_sel_locked: assert property (ctl_wr_en && !ctl_rd_data[0] |=> $stable(vector_select_bit))
    else $error("select changed");
  a_sel_taken: assert property (ctl_wr_en && ctl_rd_data[0] && !ctl_wr_data[0]
    |=> vector_select_bit == $past(ctl_wr_data[1])) else $error("select lost");
  a_window_open: assert property (ctl_wr_en && ctl_wr_data[0] |=> ctl_rd_data[0] && $stable(vector_select_bit))
    else $error("window");
  cover property (reset_fetch.valid && !boot_reset_fuse);
  cover property (vector_fetch.valid && vector_select_bit);
  cover property (ctl_wr_en && ctl_rd_data[0] && ctl_wr_data[1]);
endmodule // ivp_props
bind ivp_top ivp_props u_props (.*);

// >>> tb/ivp_core_model.sv
// Core side model issuing interrupt acknowledges
`timescale 1ns/1ps
module ivp_core_model (
  input wire logic       sys_clk,
  input wire logic       go,
  input wire logic [4:0] src,
  output ivp_pkg::ivp_ack_t ack_in
);
  // Idle source toggles so a stale number is never trusted
  always_ff @(posedge sys_clk)
  begin
    ack_in.valid <= go;
    ack_in.src   <= go ? src : ~ack_in.src;
  end
endmodule // ivp_core_model

// >>> tb/ivp_top_tb_top.sv
// Testbench for the vector placement block
`timescale 1ns/1ps
module ivp_top_tb_top;
  logic sys_clk = 0, resetn = 0, fuse = 1, p8 = 0, wr_en = 0, go = 0, sel, rdy;
  logic [12:0] bsa = 13'h0000;
  logic [7:0] wr_d = 8'h00, rd;
  logic [4:0] src = 5'h00;
  ivp_pkg::ivp_ack_t ack;
  ivp_pkg::ivp_fetch_t rf, vf;
  int miscompares = 0, check_count = 0, boot, last, msel, n;
  initial forever #5 sys_clk = ~sys_clk;
  ivp_core_model core (.sys_clk(sys_clk), .go(go), .src(src), .ack_in(ack));
  ivp_top dut (.sys_clk(sys_clk), .resetn(resetn), .boot_reset_fuse(fuse), .part_is_8k(p8),
    .boot_start_addr(bsa), .ctl_wr_en(wr_en), .ctl_wr_data(wr_d), .ctl_rd_data(rd), .ack_in(ack),
    .reset_fetch(rf), .vector_fetch(vf), .vector_select_bit(sel), .straps_ready(rdy));
  task ck(input bit ok);
  begin
    check_count++;
    if (!ok)
    begin
      miscompares++;
      $display("ERROR %0t model mismatch", $time);
    end
  end
  endtask
  task results;
  begin
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task wr(input logic [7:0] d);
  begin
    @(posedge sys_clk);
    wr_en <= 1'b1;
    wr_d <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  end
  endtask
  task rst(input logic f, input logic p);
  begin
    @(posedge sys_clk);
    resetn <= 1'b0;
    fuse <= f;
    p8 <= p;
    bsa <= 13'($urandom);
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    for (n = 1; n < 20; n++)
    begin
      @(posedge sys_clk);
      #1;
      if (rdy === 1'b1)
        break;
    end
    boot = p ? 'hC00 : bsa;
    msel = 0;
    ck(n == 4);
    ck(rd === 8'h00);
    ck(rf.valid === 1'b1 && rf.addr === 13'(f ? 0 : boot));
  end
  endtask
  task ackv(input logic [4:0] s);
  begin
    @(posedge sys_clk);
    go <= 1'b1;
    src <= s;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    #1;
    if (s < 25)
      last = ((msel ? boot : 0) + (s + 1) * (p8 ? 1 : 2)) & 'h1FFF;
    ck(vf.valid === (s < 25) && vf.addr === 13'(last));
    if (s == 0)
      ck(vf.addr === 13'((msel ? boot : 0) + (p8 ? 1 : 2)));
    if (s == 24)
      ck(vf.addr === 13'((msel ? boot : 0) + (p8 ? 'h19 : 'h32)));
  end
  endtask
  initial
  begin
    void'($urandom(32'hb8dd78a1));
    for (int c = 0; c < 4; c++)
    begin
      rst(c[0], c[1]);
      for (int v = 0; v < 2; v++)
      begin
        wr(8'h01);
        wr({6'h00, v[0], 1'b0});
        msel = v;
        #1;
        ck(sel === v[0] && rd === {6'h00, v[0], 1'b0});
        // Last pass sends an out-of-range source
        for (int s = 0; s < 26; s++)
          ackv(s == 25 ? 5'($urandom_range(31, 25)) : 5'(s));
      end
      // Fourth cycle after the opening write is the last one taken
      wr(8'h01);
      repeat (2) @(posedge sys_clk);
      wr(8'h00);
      #1;
      ck(sel === 1'b0);
      // A second opening write restarts the window and leaves select alone
      wr(8'h01);
      wr(8'h03);
      #1;
      ck(sel === 1'b0 && rd === 8'h01);
      @(posedge sys_clk);
      wr(8'h02);
      #1;
      ck(sel === 1'b1);
      // Fifth cycle after the opening write is refused
      wr(8'h01);
      repeat (3) @(posedge sys_clk);
      wr(8'h00);
      #1;
      ck(sel === 1'b1);
    end
    results;
  end
  initial
  begin
    #100000;
    miscompares++;
    results;
  end
endmodule // ivp_top_tb_top
